// ### inc/nvme_seq_pkg.sv
package nvme_seq_pkg;
	// Register offsets of user 0; user 1 sits at the same place plus the user offset
	localparam logic [15:0] OFS_ADR_LO = 16'h0000;
	localparam logic [15:0] OFS_ADR_HI = 16'h0004;
	localparam logic [15:0] OFS_LEN_LO = 16'h0008;
	localparam logic [15:0] OFS_LEN_HI = 16'h000C;
	localparam logic [15:0] OFS_CMD = 16'h0010;
	localparam logic [15:0] OFS_PATT = 16'h0014;
	localparam logic [15:0] OFS_RATE = 16'h0018;
	localparam logic [15:0] OFS_STS = 16'h0100;
	localparam logic [15:0] OFS_ERR = 16'h0104;
	localparam logic [15:0] OFS_CNT_LO = 16'h0178;
	localparam logic [15:0] OFS_CNT_HI = 16'h017C;
	localparam logic [15:0] SECOND_USER_OFFSET = 16'h0200;
	// Memory windows and shared registers
	localparam logic [15:0] IDEN_BASE = 16'h2000;
	localparam logic [15:0] IDEN_SIZE = 16'h2000;
	localparam logic [15:0] CTM_BASE = 16'h4000;
	localparam logic [15:0] CTM_SIZE = 16'h2000;
	localparam logic [15:0] SUBM_BASE = 16'h6000;
	localparam logic [15:0] SUBM_SIZE = 16'h0040;
	localparam logic [15:0] OFS_TIMEOUT = 16'h8000;
	localparam logic [15:0] OFS_LINK = 16'h8100;
	localparam logic [15:0] OFS_CAP_LO = 16'h8120;
	localparam logic [15:0] OFS_CAP_HI = 16'h8124;
	// Command codes
	localparam logic [2:0] CMD_IDENTIFY = 3'h0;
	localparam logic [2:0] CMD_SHUTDOWN = 3'h1;
	localparam logic [2:0] CMD_WRITE = 3'h2;
	localparam logic [2:0] CMD_READ = 3'h3;
	localparam logic [2:0] CMD_CUSTOM = 3'h4;
	localparam logic [2:0] CMD_FLUSH = 3'h6;
	// Status word fields
	localparam int STS_BUSY = 0;
	localparam int STS_ERR = 1;
	localparam int STS_VFAIL = 2;
	localparam int STS_GEN = 3;
	localparam int STS_CREADY = 31;
	localparam int LINK_LO = 2;
	localparam int LINK_HI = 16;
	// Reset values and sizes
	localparam logic [31:0] TIMEOUT_RST = 32'h0000_FFFF;
	localparam int CMD_UNITS = 8;
	localparam int MEM_AW = 11;
	localparam int SUBM_WORDS = 16;

	typedef enum logic [2:0] {ST_IDLE, ST_ISSUE, ST_WAIT, ST_RUN, ST_DEAD} seq_state_t;

	typedef struct packed {
		logic valid;
		logic [2:0] code;
	} core_req_t;

	typedef struct packed {
		logic busy;
		logic error;
		logic cmd_ready;
		logic done;
		logic [31:0] err_type;
	} core_sts_t;

	typedef struct packed {
		logic we;
		logic [MEM_AW-1:0] addr;
		logic [31:0] data;
	} mem_wr_t;

	typedef struct packed {
		logic [47:0] start_addr;
		logic [47:0] length;
		logic [4:0] pattern;
		logic [6:0] rate;
	} user_param_t;
endpackage

// ### src/seq_word_ram.sv
`timescale 1ns/100ps
`default_nettype none
module seq_word_ram #(
	parameter int AW = 11,
	parameter int DW = 32
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Write port
	input wire logic we,
	input wire logic [AW-1:0] waddr,
	input wire logic [DW-1:0] wdata,
	// Read port
	input wire logic [AW-1:0] raddr,
	output logic [DW-1:0] rdata
);
	logic [DW-1:0] mem [2**AW];
	logic [DW-1:0] rdata_ff;

	if (AW < 1 || AW > 16) $error("seq_word_ram: AW out of range");

	always_ff @(posedge clk_sys) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rdata_ff <= '0;
		end else begin
			rdata_ff <= mem[raddr];
		end
	end

	assign rdata = rdata_ff;
endmodule
`default_nettype wire

// ### src/traffic_gen.sv
`timescale 1ns/100ps
`default_nettype none
module traffic_gen #(
	parameter int DW = 32,
	parameter int CNT_W = 45
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Control
	input wire logic start,
	input wire logic [47:0] length,
	input wire logic [2:0] pattern,
	output logic busy,
	output logic fail,
	output logic [CNT_W-1:0] done_count,
	// Command side toward the core
	output logic cmd_valid,
	input wire logic cmd_ready,
	input wire logic cmd_done,
	// Data beats
	input wire logic beat_valid,
	input wire logic [DW-1:0] beat_in,
	output logic [DW-1:0] beat_out
);
	import nvme_seq_pkg::*;

	logic busy_ff, fail_ff;
	logic [CNT_W-1:0] total, issued_ff, done_ff;
	logic [DW-1:0] beat_ff, data_ff;

	if (CNT_W < 1 || CNT_W > 45 || DW < 32) $error("traffic_gen: unsupported width");

	function automatic logic [DW-1:0] pat(input logic [2:0] sel, input logic [DW-1:0] n);
		case (sel)
			3'h0: pat = n;
			3'h1: pat = ~n;
			3'h2: pat = '0;
			3'h3: pat = '1;
			default: pat = n ^ {n[DW-17:0], n[DW-1:DW-16]} ^ {DW{n[0]}};
		endcase
	endfunction

	// Whole commands, each of a fixed number of 512-byte units
	assign total = CNT_W'(length[47:3]) + CNT_W'(|length[2:0]);
	assign cmd_valid = busy_ff & (issued_ff < total);

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			busy_ff <= 1'b0;
			issued_ff <= '0;
			done_ff <= '0;
		end else if (start) begin
			busy_ff <= (total != '0);
			issued_ff <= '0;
			done_ff <= '0;
		end else begin
			if (cmd_valid && cmd_ready) begin
				issued_ff <= issued_ff + 1'b1;
			end
			if (busy_ff && cmd_done) begin
				done_ff <= done_ff + 1'b1;
				if (done_ff + 1'b1 == total) begin
					busy_ff <= 1'b0;
				end
			end
		end
	end

	// Each beat is checked against, or filled with, the selected pattern
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			beat_ff <= '0;
			data_ff <= '0;
			fail_ff <= 1'b0;
		end else if (start) begin
			beat_ff <= '0;
			data_ff <= pat(pattern, '0);
			fail_ff <= 1'b0;
		end else if (busy_ff && beat_valid) begin
			beat_ff <= beat_ff + 1'b1;
			data_ff <= pat(pattern, beat_ff + 1'b1);
			if (beat_in != pat(pattern, beat_ff)) begin
				fail_ff <= 1'b1;
			end
		end
	end

	assign busy = busy_ff;
	assign fail = fail_ff;
	assign done_count = done_ff;
	assign beat_out = data_ff;
endmodule
`default_nettype wire

// ### src/nvme_test_command_sequencer.sv
//Contract
// [RL1] Host polls link status until link-up reads one before any command.
// [RL2] Both users' busy bits read zero once core init is done; error stops init.
// [RL3] Link status word shows lane count and speed in bits 16 down to 2.
// [RL4] Code 000b on user 0 issues Identify and raises user-0 busy.
// [RL5] Identify data sits in identify memory before user-0 busy drops.
// [RL6] Error bit 1 set: host reads the 32-bit error cause and stops.
// [RL7] Host writes address, length, pattern, rate per user; user 1 at offset.
// [RL8] Code 011b on user 0 starts Read; 010b on user 1 starts Write.
// [RL9] Issued Write or Read raises status bits 0 and 3 of that user.
// [RL10] User-0 status bit 2 sets on read-data mismatch; host keeps running.
// [RL11] Bit 3 clears when generator finishes; bit 0 when core finishes.
// [RL12] Host reads completed-command count once per second during transfer.
// [RL13] Host sees transfer done only when bits 0 and 3 both read zero.
// [RL14] SMART: submission entry loaded, then code 100b raises user-0 busy.
// [RL15] SMART log data sits in custom memory before user-0 busy drops.
// [RL16] Flush: entry loaded, code 110b issued, user-0 busy rises.
// [RL17] Secure Erase: entry loaded, timeout set to zero, then code 100b.
// [RL18] After Secure Erase host restores timeout to its default.
// [RL19] Code 001b on user 0 issues Shutdown and raises user-0 busy.
// [RL20] After Shutdown completes no further command is accepted until power cycle.
// [RL21] Invalid transfer parameters: host cancels without writing a command.
// [RL22] Write code on user 1 pulses start to write source, which requests.
// [RL23] Host writes a new command only while that user's busy bits are zero.
//
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module nvme_test_command_sequencer #(
	parameter int DW = 32,
	parameter int CNT_W = 45
) (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// User 0 toward the core: admin and read traffic
	output nvme_seq_pkg::core_req_t u0_req,
	input wire nvme_seq_pkg::core_sts_t u0_sts,
	output nvme_seq_pkg::user_param_t u0_param,
	input wire logic rd_beat_valid,
	input wire logic [DW-1:0] rd_beat_data,
	// User 1 toward the core: write traffic
	output nvme_seq_pkg::core_req_t u1_req,
	input wire nvme_seq_pkg::core_sts_t u1_sts,
	output nvme_seq_pkg::user_param_t u1_param,
	input wire logic wr_beat_ready,
	output logic [DW-1:0] wr_beat_data,
	// Returned data from the core
	input wire nvme_seq_pkg::mem_wr_t iden_wr,
	input wire nvme_seq_pkg::mem_wr_t ctm_wr,
	// Custom command entry and shared settings
	output logic [32*nvme_seq_pkg::SUBM_WORDS-1:0] custom_submission_entry,
	output logic [31:0] command_timeout_setting,
	input wire logic [31:0] link_status_word,
	input wire logic [47:0] disk_capacity_words
);
	import nvme_seq_pkg::*;

	localparam int NU = 2;

	// Count readback splits the counter at bit 32, so it must be wider than one word
	if (DW < 32 || CNT_W < 33 || CNT_W > 45) $error("nvme_test_command_sequencer: unsupported width");

	// Bus decode
	logic acc, wr_acc, usr, rd_done_ff, hit;
	logic [15:0] loc;
	logic [31:0] rd_val, prdata_ff;
	logic [31:0] iden_rdata, ctm_rdata;

	// User registers
	logic [47:0] addr_ff [NU];
	logic [47:0] len_ff [NU];
	logic [4:0] patt_ff [NU];
	logic [6:0] rate_ff [NU];
	logic [31:0] subm_ff [SUBM_WORDS];
	logic [31:0] timeout_ff;
	logic [31:0] sts_word [NU];
	core_sts_t sts [NU];

	// Sequencer and generators
	seq_state_t state_ff, nxt_state;
	logic [2:0] code_ff;
	logic cmd_u0, cmd_u1, u0_idle, u1_idle, seq_start, seq_busy;
	logic [NU-1:0] gen_start, gen_busy, gen_valid, gen_fail;
	logic [CNT_W-1:0] gen_cnt [NU];

	function automatic logic in_win(input logic [15:0] a, input logic [15:0] base, input logic [15:0] size);
		in_win = (a >= base) && ({1'b0, a} < {1'b0, base} + {1'b0, size});
	endfunction

	assign acc = psel & penable;
	assign wr_acc = acc & pwrite;
	// User 1 registers alias the user 0 block one offset higher
	assign usr = (paddr[15:10] == 6'h00) & paddr[9];
	assign loc = usr ? (paddr - SECOND_USER_OFFSET) : paddr;
	assign sts[0] = u0_sts;
	assign sts[1] = u1_sts;

	// Transfer parameters per user
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int u = 0; u < NU; u++) begin
				addr_ff[u] <= '0;
				len_ff[u] <= '0;
				patt_ff[u] <= '0;
				rate_ff[u] <= '0;
			end
		end else if (wr_acc && paddr[15:10] == 6'h00) begin
			for (int u = 0; u < NU; u++) begin
				if (usr == u[0]) begin
					case (loc)
						OFS_ADR_LO: addr_ff[u][31:0] <= pwdata;
						OFS_ADR_HI: addr_ff[u][47:32] <= pwdata[15:0];
						OFS_LEN_LO: len_ff[u][31:0] <= pwdata;
						OFS_LEN_HI: len_ff[u][47:32] <= pwdata[15:0];
						OFS_PATT: patt_ff[u] <= pwdata[4:0];
						OFS_RATE: rate_ff[u] <= pwdata[6:0];
						default: ;
					endcase
				end
			end
		end
	end

	// Custom submission entry and timeout
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			for (int i = 0; i < SUBM_WORDS; i++) begin
				subm_ff[i] <= '0;
			end
			timeout_ff <= TIMEOUT_RST;
		end else if (wr_acc) begin
			if (in_win(paddr, SUBM_BASE, SUBM_SIZE)) begin
				subm_ff[paddr[5:2]] <= pwdata;
			end
			// Zero disables the core timer, needed for a long erase
			if (paddr == OFS_TIMEOUT) begin
				timeout_ff <= pwdata;
			end
		end
	end

	for (genvar i = 0; i < SUBM_WORDS; i++) begin : g_subm
		assign custom_submission_entry[32*i +: 32] = subm_ff[i];
	end
	assign command_timeout_setting = timeout_ff;

	always_comb begin
		u0_param = '{addr_ff[0], len_ff[0], patt_ff[0], rate_ff[0]};
		u1_param = '{addr_ff[1], len_ff[1], patt_ff[1], rate_ff[1]};
	end

	// Command writes; a command while busy, or after shutdown, is dropped
	assign cmd_u0 = wr_acc && paddr == OFS_CMD;
	assign cmd_u1 = wr_acc && paddr == OFS_CMD + SECOND_USER_OFFSET;
	assign u0_idle = state_ff == ST_IDLE && !gen_busy[0] && !u0_sts.busy; // RL23
	assign u1_idle = state_ff != ST_DEAD && !gen_busy[1] && !u1_sts.busy; // RL20
	assign seq_start = cmd_u0 && u0_idle && (pwdata[2:0] == CMD_IDENTIFY || pwdata[2:0] == CMD_SHUTDOWN
		|| pwdata[2:0] == CMD_CUSTOM || pwdata[2:0] == CMD_FLUSH); // RL4 RL14 RL16 RL19
	assign gen_start[0] = cmd_u0 && u0_idle && pwdata[2:0] == CMD_READ; // RL8
	assign gen_start[1] = cmd_u1 && u1_idle && pwdata[2:0] == CMD_WRITE; // RL22

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			code_ff <= CMD_IDENTIFY;
		end else if (seq_start) begin
			code_ff <= pwdata[2:0];
		end
	end

	// Admin sequence on user 0
	always_comb begin
		nxt_state = state_ff;
		case (state_ff)
			ST_IDLE: begin
				if (seq_start) begin
					nxt_state = ST_ISSUE;
				end
			end
			ST_ISSUE: begin
				if (u0_sts.cmd_ready) begin
					nxt_state = ST_WAIT;
				end
			end
			ST_WAIT: begin
				if (u0_sts.busy) begin
					nxt_state = ST_RUN;
				end else if (u0_sts.error) begin
					nxt_state = ST_IDLE;
				end
			end
			ST_RUN: begin
				if (!u0_sts.busy) begin
					nxt_state = (code_ff == CMD_SHUTDOWN && !u0_sts.error) ? ST_DEAD : ST_IDLE; // RL20
				end
			end
			ST_DEAD: nxt_state = ST_DEAD;
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	assign seq_busy = state_ff == ST_ISSUE || state_ff == ST_WAIT || state_ff == ST_RUN;

	always_comb begin
		u0_req.valid = (state_ff == ST_ISSUE) | gen_valid[0];
		u0_req.code = gen_busy[0] ? CMD_READ : code_ff; // RL8
		u1_req.valid = gen_valid[1]; // RL22
		u1_req.code = CMD_WRITE;
	end

	// Test traffic: read checker on user 0, write source on user 1
	traffic_gen #(.DW(DW), .CNT_W(CNT_W)) u_read_pattern_checker (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.start(gen_start[0]),
		.length(len_ff[0]),
		.pattern(patt_ff[0][2:0]),
		.busy(gen_busy[0]),
		.fail(gen_fail[0]),
		.done_count(gen_cnt[0]),
		.cmd_valid(gen_valid[0]),
		.cmd_ready(u0_sts.cmd_ready),
		.cmd_done(u0_sts.done),
		.beat_valid(rd_beat_valid),
		.beat_in(rd_beat_data),
		.beat_out()
	);

	traffic_gen #(.DW(DW), .CNT_W(CNT_W)) u_write_pattern_source (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.start(gen_start[1]),
		.length(len_ff[1]),
		.pattern(patt_ff[1][2:0]),
		.busy(gen_busy[1]),
		.fail(gen_fail[1]),
		.done_count(gen_cnt[1]),
		.cmd_valid(gen_valid[1]),
		.cmd_ready(u1_sts.cmd_ready),
		.cmd_done(u1_sts.done),
		.beat_valid(wr_beat_ready),
		.beat_in(wr_beat_data),
		.beat_out(wr_beat_data)
	);

	// Returned data memories; a host write colliding with a core write is lost
	seq_word_ram #(.AW(MEM_AW), .DW(32)) u_identify_data_memory (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.we(iden_wr.we),
		.waddr(iden_wr.addr),
		.wdata(iden_wr.data),
		.raddr(paddr[MEM_AW+1:2]),
		.rdata(iden_rdata)
	);

	seq_word_ram #(.AW(MEM_AW), .DW(32)) u_custom_command_memory (
		.clk_sys(clk_sys),
		.nrst(nrst),
		.we(ctm_wr.we | (wr_acc & in_win(paddr, CTM_BASE, CTM_SIZE))),
		.waddr(ctm_wr.we ? ctm_wr.addr : paddr[MEM_AW+1:2]),
		.wdata(ctm_wr.we ? ctm_wr.data : pwdata),
		.raddr(paddr[MEM_AW+1:2]),
		.rdata(ctm_rdata)
	);

	// Status words; busy also covers a pending request, and for user 0 a last data write
	for (genvar u = 0; u < NU; u++) begin : g_sts
		always_comb begin
			sts_word[u] = '0;
			sts_word[u][STS_BUSY] = sts[u].busy | gen_valid[u]; // RL9 RL11
			sts_word[u][STS_ERR] = sts[u].error; // RL2 RL6
			sts_word[u][STS_GEN] = gen_busy[u]; // RL9 RL11
			sts_word[u][STS_CREADY] = sts[u].cmd_ready;
		end
	end

	// Read data mux
	always_comb begin
		rd_val = '0;
		hit = 1'b1;
		if (in_win(paddr, IDEN_BASE, IDEN_SIZE)) begin
			rd_val = iden_rdata;
		end else if (in_win(paddr, CTM_BASE, CTM_SIZE)) begin
			rd_val = ctm_rdata;
		end else if (in_win(paddr, SUBM_BASE, SUBM_SIZE)) begin
			rd_val = subm_ff[paddr[5:2]];
		end else if (paddr[15:10] == 6'h00) begin
			case (loc)
				OFS_STS: begin
					rd_val = sts_word[usr];
					if (!usr) begin
						rd_val[STS_BUSY] = sts_word[0][STS_BUSY] | seq_busy | iden_wr.we | ctm_wr.we; // RL5 RL15
						rd_val[STS_VFAIL] = gen_fail[0]; // RL10
					end
				end
				OFS_ERR: rd_val = sts[usr].err_type; // RL6
				OFS_CNT_LO: rd_val = gen_cnt[usr][31:0];
				OFS_CNT_HI: rd_val = 32'(gen_cnt[usr][CNT_W-1:32]);
				OFS_ADR_LO, OFS_ADR_HI, OFS_LEN_LO, OFS_LEN_HI, OFS_CMD, OFS_PATT, OFS_RATE: rd_val = '0;
				default: hit = 1'b0;
			endcase
		end else begin
			case (paddr)
				OFS_TIMEOUT: rd_val = timeout_ff;
				OFS_LINK: rd_val = {15'h0000, link_status_word[LINK_HI:LINK_LO], 2'h0} | {31'h0, link_status_word[0]}; // RL3
				OFS_CAP_LO: rd_val = disk_capacity_words[31:0];
				OFS_CAP_HI: rd_val = {16'h0000, disk_capacity_words[47:32]};
				default: hit = 1'b0;
			endcase
		end
	end

	// Reads take one wait state so the memory output can be registered
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			rd_done_ff <= 1'b0;
			prdata_ff <= '0;
		end else begin
			rd_done_ff <= acc & ~pwrite & ~rd_done_ff;
			if (acc && !pwrite && !rd_done_ff) begin
				prdata_ff <= rd_val;
			end
		end
	end

	assign pready = acc & (pwrite | rd_done_ff);
	assign pslverr = pready & ~hit;
	assign prdata = prdata_ff;
endmodule
`default_nettype wire

// ### sim/seq_props.sv
`timescale 1ns/100ps
`default_nettype none
module seq_props (
	// Clock and reset
	input wire logic clk_sys,
	input wire logic nrst,
	// Register bus
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [15:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic pready,
	// Core side and settings
	input wire nvme_seq_pkg::core_req_t u0_req,
	input wire nvme_seq_pkg::core_sts_t u0_sts,
	input wire nvme_seq_pkg::core_req_t u1_req,
	input wire nvme_seq_pkg::user_param_t u1_param,
	input wire logic [32*nvme_seq_pkg::SUBM_WORDS-1:0] custom_submission_entry,
	input wire logic [31:0] command_timeout_setting
);
	import nvme_seq_pkg::*;
	logic cmd_wr_ff, u1_wr_ff;
	logic [2:0] code_ff;
	wire logic wr_acc = psel && penable && pwrite;
	// A fresh admin request must trace back to the command write one edge earlier
	always_ff @(posedge clk_sys or negedge nrst) begin
		if (!nrst) begin
			cmd_wr_ff <= 1'b0;
			u1_wr_ff <= 1'b0;
			code_ff <= 3'h0;
		end else begin
			cmd_wr_ff <= wr_acc && pready && paddr == OFS_CMD;
			u1_wr_ff <= wr_acc && pready && paddr == OFS_CMD + SECOND_USER_OFFSET && pwdata[2:0] == CMD_WRITE;
			code_ff <= pwdata[2:0];
		end
	end
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!nrst);
	a_write_no_wait: assert property (wr_acc |-> pready)
		else $error("write access not answered at once");
	a_read_one_wait: assert property (psel && !pwrite && $rose(penable) |-> !pready ##1 pready)
		else $error("read access not answered after one wait");
	a_ready_gate: assert property (pready |-> psel && penable)
		else $error("ready outside an access cycle");
	a_req_hold: assert property (u0_req.valid && !u0_sts.cmd_ready |=> u0_req.valid)
		else $error("user 0 request dropped before accept");
	a_u1_code: assert property (u1_req.valid |-> u1_req.code == CMD_WRITE)
		else $error("user 1 request with wrong code");
	a_u1_cause: assert property ($rose(u1_req.valid) |-> u1_wr_ff)
		else $error("user 1 request without write command");
	a_req_cause: assert property ($rose(u0_req.valid) && u0_req.code != CMD_READ |-> cmd_wr_ff && code_ff == u0_req.code)
		else $error("user 0 request without matching command write");
	a_timeout_load: assert property (wr_acc && paddr == OFS_TIMEOUT |=> command_timeout_setting == $past(pwdata))
		else $error("timeout setting not loaded");
	a_entry_load: assert property (wr_acc && paddr == SUBM_BASE |=> custom_submission_entry[31:0] == $past(pwdata))
		else $error("submission word 0 not loaded");
	a_param_load: assert property (wr_acc && paddr == OFS_ADR_LO + SECOND_USER_OFFSET |=> u1_param.start_addr[31:0] == $past(pwdata))
		else $error("user 1 start address not loaded");
endmodule
bind nvme_test_command_sequencer seq_props u_props (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .pready,
	.u0_req, .u0_sts, .u1_req, .u1_param, .custom_submission_entry, .command_timeout_setting);
`default_nettype wire

// ### sim/tb_top.sv
`timescale 1ns/100ps
`default_nettype none
module tb_top;
	import nvme_seq_pkg::*;
	logic clk_sys, nrst, psel, penable, pwrite, pready, pslverr, rd_beat_valid, wr_beat_ready, re;
	logic [15:0] paddr;
	logic [31:0] pwdata, prdata, link_status_word, rd_beat_data, wr_beat_data, command_timeout_setting, rv;
	logic [47:0] disk_capacity_words;
	logic [32*SUBM_WORDS-1:0] custom_submission_entry;
	core_req_t u0_req, u1_req;
	core_sts_t u0_sts, u1_sts;
	user_param_t u0_param, u1_param;
	mem_wr_t iden_wr, ctm_wr;
	int mismatches, n_tests;
	nvme_test_command_sequencer uut (.clk_sys, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .u0_req, .u0_sts, .u0_param, .rd_beat_valid, .rd_beat_data, .u1_req, .u1_sts, .u1_param,
		.wr_beat_ready, .wr_beat_data, .iden_wr, .ctm_wr, .custom_submission_entry, .command_timeout_setting,
		.link_status_word, .disk_capacity_words);
	initial begin
		clk_sys = 1'b0;
		forever #2.5 clk_sys = ~clk_sys;
	end
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", n_tests, mismatches);
		if (mismatches == 0 && n_tests > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Idle cycle first, so a release is never overwritten in the same step
	task automatic apb(input logic w, input logic [15:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 20);
		rv = prdata;
		re = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 20) chk("pready", 32'h0, 32'h1);
	endtask
	task automatic rd(input string nm, input logic [15:0] a, input logic [31:0] m, input logic [31:0] e);
		apb(1'b0, a, 32'h0);
		chk(nm, rv & m, e);
	endtask
	task automatic accept0(input logic [2:0] code);
		@(posedge clk_sys);
		chk("u0 req", {u0_req.valid, u0_req.code}, {1'b1, code});
		u0_sts.cmd_ready <= 1'b1;
		@(posedge clk_sys);
		u0_sts.cmd_ready <= 1'b0;
		u0_sts.busy <= 1'b1;
		@(posedge clk_sys);
		chk("u0 req drop", u0_req.valid, 1'b0);
	endtask
	// Core returns one data word while busy, then finishes
	task automatic admin(input logic [2:0] code, input logic [15:0] ma, input logic [31:0] md);
		rd("idle", OFS_STS, 32'h1, 32'h0);
		apb(1'b1, OFS_CMD, {29'h0, code});
		accept0(code);
		rd("busy", OFS_STS, 32'h1, 32'h1);
		if (code == CMD_IDENTIFY) iden_wr <= '{1'b1, 11'h005, md};
		else ctm_wr <= '{1'b1, 11'h007, md};
		@(posedge clk_sys);
		iden_wr.we <= 1'b0;
		ctm_wr.we <= 1'b0;
		@(posedge clk_sys);
		u0_sts.busy <= 1'b0;
		rd("done", OFS_STS, 32'h1, 32'h0);
		rd("mem", ma, 32'hFFFF_FFFF, md);
	endtask
	task automatic read_run;
		apb(1'b1, OFS_LEN_LO, 32'h8);
		apb(1'b1, OFS_PATT, 32'h2);
		chk("no cmd yet", u0_req.valid, 1'b0);
		chk("u0 len", u0_param.length[31:0], 32'h8);
		apb(1'b1, OFS_CMD, {29'h0, CMD_READ});
		accept0(CMD_READ);
		rd("rd busy", OFS_STS, 32'h9, 32'h9);
		rd_beat_valid <= 1'b1;
		rd_beat_data <= 32'hFFFF_FFFF;
		@(posedge clk_sys);
		rd_beat_valid <= 1'b0;
		u0_sts.done <= 1'b1;
		@(posedge clk_sys);
		u0_sts.done <= 1'b0;
		rd("rd gen", OFS_STS, 32'hD, 32'h5);
		rd("rd count", OFS_CNT_LO, 32'hFFFF_FFFF, 32'h1);
		u0_sts.busy <= 1'b0;
		rd("rd end", OFS_STS, 32'hF, 32'h4);
	endtask
	task automatic write_run;
		apb(1'b1, SECOND_USER_OFFSET + OFS_ADR_LO, 32'h0000_0100);
		apb(1'b1, SECOND_USER_OFFSET + OFS_LEN_LO, 32'h8);
		chk("u1 addr", u1_param.start_addr[31:0], 32'h0000_0100);
		apb(1'b1, SECOND_USER_OFFSET + OFS_CMD, {29'h0, CMD_READ});
		@(posedge clk_sys);
		chk("u1 reserved", u1_req.valid, 1'b0);
		apb(1'b1, SECOND_USER_OFFSET + OFS_CMD, {29'h0, CMD_WRITE});
		@(posedge clk_sys);
		chk("u1 req", {u1_req.valid, u1_req.code}, {1'b1, CMD_WRITE});
		u1_sts.cmd_ready <= 1'b1;
		wr_beat_ready <= 1'b1;
		@(posedge clk_sys);
		u1_sts.cmd_ready <= 1'b0;
		wr_beat_ready <= 1'b0;
		u1_sts.busy <= 1'b1;
		rd("wr busy", SECOND_USER_OFFSET + OFS_STS, 32'h9, 32'h9);
		chk("wr data", wr_beat_data, 32'h1);
		u1_sts.done <= 1'b1;
		@(posedge clk_sys);
		u1_sts.done <= 1'b0;
		u1_sts.busy <= 1'b0;
		rd("wr end", SECOND_USER_OFFSET + OFS_STS, 32'h9, 32'h0);
		rd("wr count", SECOND_USER_OFFSET + OFS_CNT_LO, 32'hFFFF_FFFF, 32'h1);
	endtask
	initial begin
		#20000;
		mismatches++;
		stop_test();
	end
	initial begin
		{nrst, psel, penable, pwrite, rd_beat_valid, wr_beat_ready} = 6'h00;
		{paddr, pwdata, rd_beat_data} = '0;
		u0_sts = '{1'b1, 1'b0, 1'b0, 1'b0, 32'h0};
		u1_sts = '{1'b1, 1'b0, 1'b0, 1'b0, 32'h0};
		iden_wr = '0;
		ctm_wr = '0;
		link_status_word = 32'hFFFF_FFFF;
		disk_capacity_words = 48'h1234_89AB_CDEF;
		mismatches = 0;
		n_tests = 0;
		repeat (6) @(posedge clk_sys);
		chk("timeout rst", command_timeout_setting, TIMEOUT_RST);
		nrst <= 1'b1;
		rd("u0 init", OFS_STS, 32'h1, 32'h1);
		rd("u1 init", SECOND_USER_OFFSET + OFS_STS, 32'h1, 32'h1);
		u0_sts.busy <= 1'b0;
		u1_sts.busy <= 1'b0;
		rd("u0 ready", OFS_STS, 32'h1, 32'h0);
		rd("u1 ready", SECOND_USER_OFFSET + OFS_STS, 32'h1, 32'h0);
		rd("link", OFS_LINK, 32'hFFFF_FFFF, 32'h0001_FFFD);
		rd("cap lo", OFS_CAP_LO, 32'hFFFF_FFFF, 32'h89AB_CDEF);
		rd("cap hi", OFS_CAP_HI, 32'h0000_FFFF, 32'h0000_1234);
		u0_sts.error <= 1'b1;
		u0_sts.err_type <= 32'hA5C3_0F01;
		rd("err flag", OFS_STS, 32'h2, 32'h2);
		rd("err cause", OFS_ERR, 32'hFFFF_FFFF, 32'hA5C3_0F01);
		u0_sts.error <= 1'b0;
		apb(1'b0, 16'h9000, 32'h0);
		chk("unmapped err", re, 1'b1);
		chk("unmapped data", rv, 32'h0);
		for (int k = 0; k < SUBM_WORDS; k++) apb(1'b1, SUBM_BASE + 16'(4 * k), 32'hC0DE_0000 + k);
		@(posedge clk_sys);
		for (int k = 0; k < SUBM_WORDS; k++) chk("entry", custom_submission_entry[32*k+:32], 32'hC0DE_0000 + k);
		admin(CMD_IDENTIFY, IDEN_BASE + 16'h0014, 32'h1D00_0001);
		admin(CMD_CUSTOM, CTM_BASE + 16'h001C, 32'h5A00_0002);
		apb(1'b1, OFS_TIMEOUT, 32'h0);
		@(posedge clk_sys);
		chk("timeout off", command_timeout_setting, 32'h0);
		admin(CMD_CUSTOM, CTM_BASE + 16'h001C, 32'h5A00_0003);
		apb(1'b1, OFS_TIMEOUT, TIMEOUT_RST);
		@(posedge clk_sys);
		chk("timeout on", command_timeout_setting, TIMEOUT_RST);
		admin(CMD_FLUSH, CTM_BASE + 16'h001C, 32'h5A00_0004);
		read_run();
		write_run();
		admin(CMD_SHUTDOWN, CTM_BASE + 16'h001C, 32'h5A00_0005);
		apb(1'b1, OFS_CMD, {29'h0, CMD_IDENTIFY});
		apb(1'b1, SECOND_USER_OFFSET + OFS_CMD, {29'h0, CMD_WRITE});
		repeat (3) begin
			@(posedge clk_sys);
			chk("locked", {u0_req.valid, u1_req.valid}, 2'b00);
		end
		stop_test();
	end
endmodule
`default_nettype wire
